/* hp_consts.svh */
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH

// ==========================================
// register offsets
`define HP_ADDR_PWR1 8'h01
`define HP_ADDR_LINE3 8'h15
`define HP_ADDR_LINE1 8'h16
`define HP_ADDR_LINE2 8'h17
`define HP_ADDR_ANTIPOP2 8'h39
`define HP_ADDR_CPUMP1 8'h4c
`define HP_ADDR_HP0 8'h60

// ==========================================
// field positions
`define HP_BIT_CLAMP 0
`define HP_BIT_MIDBUF 3
`define HP_BIT_OSC 3
`define HP_BIT_LEFT_IN 9
`define HP_BIT_RIGHT_IN 8
`define HP_BIT_CP_EN 15
`define HP_BIT_LEFT_UNSHORT 7
`define HP_BIT_LEFT_OUTP 6
`define HP_BIT_LEFT_MID 5
`define HP_BIT_RIGHT_UNSHORT 3
`define HP_BIT_RIGHT_OUTP 2
`define HP_BIT_RIGHT_MID 1

// ==========================================
// reset values
`define HP_RST_PWR1 16'h0000
`define HP_RST_LINE 16'h0001
`define HP_RST_ANTIPOP2 16'h0008
`define HP_RST_CPUMP1 16'h0000
`define HP_RST_HP0 16'h0000

// ==========================================
// timing
`define HP_CLK_PERIOD_NS 50
`define HP_STEP_UNIT_NS 62500
`define HP_STEP_UNIT_CYC ((`HP_STEP_UNIT_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)
`define HP_STEP_EXTRA_UNITS 8

`endif

/* hp_pkg.sv */
package hp_pkg;

	typedef enum logic {TMR_IDLE, TMR_RUN} tmr_phase_t;

	typedef enum logic {CP_MODE_LOW, CP_MODE_HIGH} cp_mode_t;

	typedef struct packed {
		tmr_phase_t phase;
		logic [20:0] unit_cnt;
		logic [16:0] units_left;
		logic done;
	} tmr_state_t;

	typedef struct packed {
		logic [15:0] pwr1;
		logic [15:0] line3;
		logic [15:0] line1;
		logic [15:0] line2;
		logic [15:0] antipop2;
		logic [15:0] cpump1;
		logic [15:0] hp0;
		logic [15:0] rdata;
		logic [2:0] clamp;
		logic midbuf;
		logic [1:0] in_stage;
		logic [1:0] mid_stage;
		logic [1:0] out_stage;
		logic [1:0] shorted;
		logic cp_run;
		logic cp_clk;
		logic [7:0] div_cnt;
		cp_mode_t cp_mode;
	} ctrl_state_t;

endpackage : hp_pkg

/* step_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hp_consts.svh"

module step_timer #(
	parameter logic [20:0] UNIT_CYCLES = 21'(`HP_STEP_UNIT_CYC)
) (
	input wire logic system_clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [3:0] delay_code,
	output wire logic busy,
	output wire logic done
);

	hp_pkg::tmr_state_t s_q;
	hp_pkg::tmr_state_t s_d;

	function automatic logic [16:0] units_for(input logic [3:0] code);
		units_for = (17'h00001 << code) + 17'(`HP_STEP_EXTRA_UNITS);
	endfunction : units_for

	// ==========================================
	// step timing
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (ce)
		begin
			case (s_q.phase)
				hp_pkg::TMR_IDLE:
				begin
					if (start)
					begin
						s_d.phase = hp_pkg::TMR_RUN;
						s_d.unit_cnt = 21'h000000;
						s_d.units_left = units_for(delay_code);
					end
				end
				hp_pkg::TMR_RUN:
				begin
					if (s_q.unit_cnt == UNIT_CYCLES - 21'h000001)
					begin
						s_d.unit_cnt = 21'h000000;
						if (s_q.units_left == 17'h00001)
						begin
							s_d.phase = hp_pkg::TMR_IDLE;
							s_d.done = 1'b1;
						end
						else
							s_d.units_left = s_q.units_left - 17'h00001;
					end
					else
						s_d.unit_cnt = s_q.unit_cnt + 21'h000001;
				end
				default:
					s_d.phase = hp_pkg::TMR_IDLE;
			endcase
		end
		else
			s_d.done = s_q.done;
	end

	always_ff @(posedge system_clock)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign busy = (s_q.phase == hp_pkg::TMR_RUN);
	assign done = s_q.done;

	// ==========================================
	// checks
	logic [31:0] chk_cnt_q;
	logic [31:0] chk_len_q;

	always_ff @(posedge system_clock)
	begin
		if (!rst_n)
		begin
			chk_cnt_q <= 32'h00000000;
			chk_len_q <= 32'h00000000;
		end
		else if (ce && start && !busy)
		begin
			chk_cnt_q <= 32'h00000000;
			chk_len_q <= 32'(units_for(delay_code)) * 32'(UNIT_CYCLES);
		end
		else if (ce && busy)
			chk_cnt_q <= chk_cnt_q + 32'h00000001;
	end

	property p_step_len;
		@(posedge system_clock) disable iff (!rst_n)
		$rose(done) |-> chk_cnt_q == chk_len_q;
	endproperty
	a_step_len: assert property (p_step_len) else $error("step length wrong");

	cover property (@(posedge system_clock) disable iff (!rst_n) $rose(done));

endmodule : step_timer
`default_nettype wire

/* hp_pop_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hp_consts.svh"

module hp_pop_ctrl #(
	parameter logic [20:0] STEP_UNIT_CYCLES = 21'(`HP_STEP_UNIT_CYC),
	parameter logic [7:0] CP_DIV_HALF = 8'h04,
	parameter logic [5:0] CP_VOL_THRESH = 6'h20
) (
	input wire logic system_clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output wire logic [15:0] reg_rdata,
	input wire logic seq_wr,
	input wire logic [7:0] seq_addr,
	input wire logic [3:0] seq_start_bit,
	input wire logic [2:0] seq_width,
	input wire logic [7:0] seq_data,
	input wire logic [3:0] sequencer_step_delay,
	output wire logic seq_busy,
	output wire logic seq_step_done,
	input wire logic [2:0] input_stage_active,
	input wire logic [5:0] left_hp_volume,
	input wire logic [5:0] right_hp_volume,
	output wire logic [2:0] input_clamp_on,
	output wire logic midrail_buffer_en,
	output wire logic left_hp_input_stage_en,
	output wire logic right_hp_input_stage_en,
	output wire logic left_hp_intermediate_en,
	output wire logic right_hp_intermediate_en,
	output wire logic left_hp_output_stage_en,
	output wire logic right_hp_output_stage_en,
	output wire logic left_hp_shorted,
	output wire logic right_hp_shorted,
	output wire logic charge_pump_run,
	output wire logic charge_pump_clk,
	output wire logic charge_pump_mode_high
);

	hp_pkg::ctrl_state_t s_q;
	hp_pkg::ctrl_state_t s_d;
	logic step_take;
	logic tmr_busy;

	// masked update of one mapped register; unmapped addresses drop the write
	function automatic hp_pkg::ctrl_state_t put_reg(input hp_pkg::ctrl_state_t s,
		input logic [7:0] addr, input logic [15:0] data, input logic [15:0] mask);
		put_reg = s;
		case (addr)
			`HP_ADDR_PWR1: put_reg.pwr1 = (s.pwr1 & ~mask) | (data & mask);
			`HP_ADDR_LINE3: put_reg.line3 = (s.line3 & ~mask) | (data & mask);
			`HP_ADDR_LINE1: put_reg.line1 = (s.line1 & ~mask) | (data & mask);
			`HP_ADDR_LINE2: put_reg.line2 = (s.line2 & ~mask) | (data & mask);
			`HP_ADDR_ANTIPOP2: put_reg.antipop2 = (s.antipop2 & ~mask) | (data & mask);
			`HP_ADDR_CPUMP1: put_reg.cpump1 = (s.cpump1 & ~mask) | (data & mask);
			`HP_ADDR_HP0: put_reg.hp0 = (s.hp0 & ~mask) | (data & mask);
			default: put_reg = s;
		endcase
	endfunction : put_reg

	assign step_take = seq_wr && !tmr_busy;

	// ==========================================
	// register writes and analogue controls
	always_comb
	begin
		logic [15:0] fmask;
		fmask = 16'h0000;
		s_d = s_q;
		if (ce)
		begin
			if (reg_wr)
				s_d = put_reg(s_d, reg_addr, reg_wdata, 16'hffff);
			if (step_take)
			begin
				fmask = 16'((9'h002 << seq_width) - 9'h001) << seq_start_bit;
				s_d = put_reg(s_d, seq_addr, 16'(seq_data) << seq_start_bit, fmask);
			end
			s_d.rdata = s_q.rdata;
			if (reg_rd)
			begin
				case (reg_addr)
					`HP_ADDR_PWR1: s_d.rdata = s_q.pwr1;
					`HP_ADDR_LINE3: s_d.rdata = s_q.line3;
					`HP_ADDR_LINE1: s_d.rdata = s_q.line1;
					`HP_ADDR_LINE2: s_d.rdata = s_q.line2;
					`HP_ADDR_ANTIPOP2: s_d.rdata = s_q.antipop2;
					`HP_ADDR_CPUMP1: s_d.rdata = s_q.cpump1;
					`HP_ADDR_HP0: s_d.rdata = s_q.hp0;
					default: s_d.rdata = 16'h0000;
				endcase
			end
			// clamp only while the stage is off
			s_d.clamp[0] = s_d.line1[`HP_BIT_CLAMP] & ~input_stage_active[0];
			s_d.clamp[1] = s_d.line2[`HP_BIT_CLAMP] & ~input_stage_active[1];
			s_d.clamp[2] = s_d.line3[`HP_BIT_CLAMP] & ~input_stage_active[2];
			s_d.midbuf = s_d.antipop2[`HP_BIT_MIDBUF];
			s_d.in_stage = {s_d.pwr1[`HP_BIT_LEFT_IN], s_d.pwr1[`HP_BIT_RIGHT_IN]};
			s_d.mid_stage = {s_d.hp0[`HP_BIT_LEFT_MID], s_d.hp0[`HP_BIT_RIGHT_MID]};
			s_d.out_stage = {s_d.hp0[`HP_BIT_LEFT_OUTP], s_d.hp0[`HP_BIT_RIGHT_OUTP]};
			s_d.shorted = ~{s_d.hp0[`HP_BIT_LEFT_UNSHORT], s_d.hp0[`HP_BIT_RIGHT_UNSHORT]};
			// pump needs its enable and a running oscillator
			s_d.cp_run = s_d.cpump1[`HP_BIT_CP_EN] & s_d.pwr1[`HP_BIT_OSC];
			// pump clock divided from system clock
			if (!s_d.cp_run)
			begin
				s_d.div_cnt = 8'h00;
				s_d.cp_clk = 1'b0;
			end
			else if (s_q.div_cnt >= CP_DIV_HALF - 8'h01)
			begin
				s_d.div_cnt = 8'h00;
				s_d.cp_clk = ~s_q.cp_clk;
			end
			else
				s_d.div_cnt = s_q.div_cnt + 8'h01;
			if (left_hp_volume >= CP_VOL_THRESH || right_hp_volume >= CP_VOL_THRESH)
				s_d.cp_mode = hp_pkg::CP_MODE_HIGH;
			else
				s_d.cp_mode = hp_pkg::CP_MODE_LOW;
		end
	end

	always_ff @(posedge system_clock)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.pwr1 <= `HP_RST_PWR1;
			s_q.line1 <= `HP_RST_LINE;
			s_q.line2 <= `HP_RST_LINE;
			s_q.line3 <= `HP_RST_LINE;
			s_q.antipop2 <= `HP_RST_ANTIPOP2;
			s_q.cpump1 <= `HP_RST_CPUMP1;
			s_q.hp0 <= `HP_RST_HP0;
			s_q.clamp <= 3'h7;
			s_q.midbuf <= 1'b1;
			s_q.shorted <= 2'h3;
		end
		else
			s_q <= s_d;
	end

	// ==========================================
	// sequencer step timing
	step_timer #(
		.UNIT_CYCLES(STEP_UNIT_CYCLES)
	) u_step_timer (
		.system_clock(system_clock),
		.rst_n(rst_n),
		.ce(ce),
		.start(step_take),
		.delay_code(sequencer_step_delay),
		.busy(tmr_busy),
		.done(seq_step_done)
	);

	assign seq_busy = tmr_busy;
	assign reg_rdata = s_q.rdata;
	assign input_clamp_on = s_q.clamp;
	assign midrail_buffer_en = s_q.midbuf;
	assign left_hp_input_stage_en = s_q.in_stage[1];
	assign right_hp_input_stage_en = s_q.in_stage[0];
	assign left_hp_intermediate_en = s_q.mid_stage[1];
	assign right_hp_intermediate_en = s_q.mid_stage[0];
	assign left_hp_output_stage_en = s_q.out_stage[1];
	assign right_hp_output_stage_en = s_q.out_stage[0];
	assign left_hp_shorted = s_q.shorted[1];
	assign right_hp_shorted = s_q.shorted[0];
	assign charge_pump_run = s_q.cp_run;
	assign charge_pump_clk = s_q.cp_clk;
	assign charge_pump_mode_high = (s_q.cp_mode == hp_pkg::CP_MODE_HIGH);

	// ==========================================
	// checks
	logic host_only;
	assign host_only = ce && reg_wr && !seq_wr;

	property p_clamp_reset;
		@(posedge system_clock) disable iff (!rst_n)
		$rose(rst_n) |-> input_clamp_on == 3'h7;
	endproperty
	a_clamp_reset: assert property (p_clamp_reset) else $error("clamps not set after reset");

	property p_midbuf;
		@(posedge system_clock) disable iff (!rst_n)
		host_only && reg_addr == `HP_ADDR_ANTIPOP2
		|=> midrail_buffer_en == $past(reg_wdata[`HP_BIT_MIDBUF]);
	endproperty
	a_midbuf: assert property (p_midbuf) else $error("midrail buffer wrong");

	property p_clamp_stage;
		@(posedge system_clock) disable iff (!rst_n)
		ce ##1 input_clamp_on[0] |-> !$past(input_stage_active[0]);
	endproperty
	a_clamp_stage: assert property (p_clamp_stage) else $error("clamp on active input");

	property p_short_hold;
		@(posedge system_clock) disable iff (!rst_n)
		host_only && reg_addr == `HP_ADDR_HP0 && !reg_wdata[`HP_BIT_LEFT_UNSHORT]
		|=> left_hp_shorted;
	endproperty
	a_short_hold: assert property (p_short_hold) else $error("left short released");

	property p_in_stage;
		@(posedge system_clock) disable iff (!rst_n)
		host_only && reg_addr == `HP_ADDR_PWR1 |=> left_hp_input_stage_en ==
			$past(reg_wdata[`HP_BIT_LEFT_IN]) && right_hp_input_stage_en ==
			$past(reg_wdata[`HP_BIT_RIGHT_IN]);
	endproperty
	a_in_stage: assert property (p_in_stage) else $error("input stage enable wrong");

	property p_cp_off;
		@(posedge system_clock) disable iff (!rst_n)
		host_only && reg_addr == `HP_ADDR_CPUMP1 && !reg_wdata[`HP_BIT_CP_EN]
		|=> !charge_pump_run;
	endproperty
	a_cp_off: assert property (p_cp_off) else $error("pump runs while disabled");

	property p_cp_mode;
		@(posedge system_clock) disable iff (!rst_n)
		ce && (left_hp_volume >= CP_VOL_THRESH) |=> charge_pump_mode_high;
	endproperty
	a_cp_mode: assert property (p_cp_mode) else $error("pump mode ignores volume");

	property p_cp_clk;
		@(posedge system_clock) disable iff (!rst_n)
		!charge_pump_run |-> !charge_pump_clk;
	endproperty
	a_cp_clk: assert property (p_cp_clk) else $error("pump clock while stopped");

	property p_seq_write;
		@(posedge system_clock) disable iff (!rst_n)
		ce && step_take && !reg_wr && seq_addr == `HP_ADDR_HP0 && seq_start_bit == 4'h0
		&& seq_width == 3'h7 |=> left_hp_output_stage_en == $past(seq_data[6]);
	endproperty
	a_seq_write: assert property (p_seq_write) else $error("sequencer write lost");

	cover property (@(posedge system_clock) disable iff (!rst_n) $fell(left_hp_shorted));
	cover property (@(posedge system_clock) disable iff (!rst_n) $rose(charge_pump_run));
	cover property (@(posedge system_clock) disable iff (!rst_n) $fell(input_clamp_on[0]));

endmodule : hp_pop_ctrl
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// host side of the control interface
module host_model #(
	parameter int SETTLE_CYC = 400,
	parameter int SERVO_CYC = 40
) (
	input wire logic system_clock,
	input wire logic [15:0] reg_rdata,
	input wire logic seq_step_done,
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_addr,
	output var logic [15:0] reg_wdata,
	output var logic seq_wr,
	output var logic [7:0] seq_addr,
	output var logic [3:0] seq_start_bit,
	output var logic [2:0] seq_width,
	output var logic [7:0] seq_data,
	output var logic [3:0] sequencer_step_delay
);
	initial
	begin
		{reg_wr, reg_rd, seq_wr} = 3'h0;
		{reg_addr, reg_wdata} = 24'h0;
		{seq_addr, seq_start_bit, seq_width, seq_data, sequencer_step_delay} = 27'h0;
	end

	// ==========================================
	// bus cycles
	// released address and data lines show the inverse, so a stale value never passes
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge system_clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge system_clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	task rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge system_clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge system_clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask : rd

	// n counts edges from the taking edge to the step end
	task step(input logic [7:0] a, input logic [3:0] s, input logic [2:0] w,
		input logic [7:0] d, input logic [3:0] dl, input bit wt, output int n);
		@(negedge system_clock);
		{seq_addr, seq_start_bit, seq_width, seq_data, sequencer_step_delay} = {a, s, w, d, dl};
		seq_wr = 1'b1;
		@(negedge system_clock);
		seq_wr = 1'b0;
		{seq_addr, seq_data} = ~{a, d};
		n = 0;
		while (wt && n < 3000)
		begin
			@(negedge system_clock);
			n++;
			if (seq_step_done === 1'b1)
				break;
		end
	endtask : step

	// ==========================================
	// headphone sequences
	// oscillator then inputs
	task hp_on;
		wr(8'h01, 16'h000b);
		wr(8'h01, 16'h030b);
		repeat (SETTLE_CYC) @(negedge system_clock);
		wr(8'h60, 16'h0022);
		repeat (SERVO_CYC) @(negedge system_clock);
		wr(8'h60, 16'h0066);
		wr(8'h60, 16'h00ee);
	endtask : hp_on

	task hp_off;
		wr(8'h60, 16'h0000);
		wr(8'h01, 16'h000b);
	endtask : hp_off

	task pump_on;
		wr(8'h01, 16'h000b);
		wr(8'h4c, 16'h8000);
	endtask : pump_on
endmodule : host_model

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam int UNIT = 2;
	logic system_clock = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [2:0] stage_act = 3'h0;
	logic [5:0] vol_l = 6'h0;
	logic [5:0] vol_r = 6'h0;
	logic v1;
	int n;
	int cyc = 0;
	int num_errors = 0;
	int n_compared = 0;
	wire logic reg_wr, reg_rd, seq_wr, seq_busy, seq_done, midbuf, cp_run, cp_clk, cp_hi;
	wire logic in_l, in_r, mid_l, mid_r, out_l, out_r, sh_l, sh_r;
	wire logic [7:0] reg_addr, seq_addr, seq_data;
	wire logic [15:0] reg_wdata, rdata;
	wire logic [3:0] seq_start, seq_dly;
	wire logic [2:0] seq_width, clamp;

	always #25 system_clock = ~system_clock;

	hp_pop_ctrl #(.STEP_UNIT_CYCLES(21'(UNIT)), .CP_DIV_HALF(8'h04), .CP_VOL_THRESH(6'h20)) uut (
		.system_clock(system_clock), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .seq_wr(seq_wr),
		.seq_addr(seq_addr), .seq_start_bit(seq_start), .seq_width(seq_width),
		.seq_data(seq_data), .sequencer_step_delay(seq_dly), .seq_busy(seq_busy),
		.seq_step_done(seq_done), .input_stage_active(stage_act), .left_hp_volume(vol_l),
		.right_hp_volume(vol_r), .input_clamp_on(clamp), .midrail_buffer_en(midbuf),
		.left_hp_input_stage_en(in_l), .right_hp_input_stage_en(in_r),
		.left_hp_intermediate_en(mid_l), .right_hp_intermediate_en(mid_r),
		.left_hp_output_stage_en(out_l), .right_hp_output_stage_en(out_r),
		.left_hp_shorted(sh_l), .right_hp_shorted(sh_r), .charge_pump_run(cp_run),
		.charge_pump_clk(cp_clk), .charge_pump_mode_high(cp_hi));

	host_model u_host (
		.system_clock(system_clock), .reg_rdata(rdata), .seq_step_done(seq_done), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .seq_wr(seq_wr),
		.seq_addr(seq_addr), .seq_start_bit(seq_start), .seq_width(seq_width),
		.seq_data(seq_data), .sequencer_step_delay(seq_dly));

	// ==========================================
	// checking and closing
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		u_host.rd(a, v);
		chk(nm, v, exp);
	endtask : rdchk

	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// a hung step wait must not stall the run
	always @(posedge system_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	// ==========================================
	// tests
	initial
	begin
		repeat (2) @(negedge system_clock);
		rst_n = 1'b1;
		rdchk("pwr1", 8'h01, 16'h0000);
		rdchk("line3", 8'h15, 16'h0001);
		rdchk("line1", 8'h16, 16'h0001);
		rdchk("line2", 8'h17, 16'h0001);
		rdchk("antipop2", 8'h39, 16'h0008);
		rdchk("cpump1", 8'h4c, 16'h0000);
		rdchk("hp0", 8'h60, 16'h0000);
		rdchk("unmapped", 8'h20, 16'h0000);
		chk("clamp", 16'(clamp), 16'h0007);
		chk("midbuf", 16'(midbuf), 16'h0001);
		chk("shorted", 16'({sh_l, sh_r}), 16'h0003);
		chk("enables", 16'({in_l, in_r, mid_l, mid_r, out_l, out_r, cp_run}), 16'h0);
		$display("test reset done");
		u_host.wr(8'h16, 16'h0000);
		chk("clamp", 16'(clamp), 16'h0006);
		stage_act = 3'h2;
		@(negedge system_clock);
		chk("clamp", 16'(clamp), 16'h0004);
		stage_act = 3'h0;
		ce = 1'b0;
		u_host.wr(8'h39, 16'h0000);
		ce = 1'b1;
		chk("midbuf", 16'(midbuf), 16'h0001);
		u_host.wr(8'h39, 16'h0000);
		chk("midbuf", 16'(midbuf), 16'h0000);
		u_host.wr(8'h16, 16'h0001);
		chk("clamp", 16'(clamp), 16'h0007);
		$display("test clamps done");
		u_host.hp_on();
		chk("enables", 16'({in_l, in_r, mid_l, mid_r, out_l, out_r}), 16'h3f);
		chk("shorted", 16'({sh_l, sh_r}), 16'h0);
		rdchk("hp0", 8'h60, 16'h00ee);
		u_host.hp_off();
		chk("enables", 16'({in_l, in_r, mid_l, mid_r, out_l, out_r}), 16'h0);
		u_host.wr(8'h60, 16'h0008);
		chk("shorted", 16'({sh_l, sh_r}), 16'h0002);
		u_host.wr(8'h60, 16'h0000);
		$display("test host sequence done");
		u_host.wr(8'h01, 16'h0000);
		u_host.wr(8'h4c, 16'h8000);
		chk("pump", 16'({cp_run, cp_clk}), 16'h0);
		u_host.pump_on();
		chk("pump", 16'(cp_run), 16'h1);
		v1 = cp_clk;
		repeat (4) @(negedge system_clock);
		chk("pump_clk", 16'(cp_clk), 16'(!v1));
		vol_l = 6'h20;
		@(negedge system_clock);
		chk("mode", 16'(cp_hi), 16'h1);
		vol_l = 6'h1f;
		vol_r = 6'h20;
		@(negedge system_clock);
		chk("mode", 16'(cp_hi), 16'h1);
		vol_r = 6'h1f;
		@(negedge system_clock);
		chk("mode", 16'(cp_hi), 16'h0);
		u_host.wr(8'h4c, 16'h0000);
		chk("pump", 16'({cp_run, cp_clk}), 16'h0);
		$display("test pump done");
		u_host.step(8'h4c, 4'hf, 3'h0, 8'h01, 4'h0, 1'b1, n);
		chk("step_len", 16'(n), 16'(9 * UNIT));
		chk("pump", 16'(cp_run), 16'h1);
		u_host.step(8'h01, 4'h8, 3'h1, 8'h03, 4'h0, 1'b1, n);
		chk("step_len", 16'(n), 16'(9 * UNIT));
		chk("inputs", 16'({in_l, in_r}), 16'h3);
		u_host.step(8'h60, 4'h0, 3'h5, 8'h22, 4'h0, 1'b1, n);
		chk("step_len", 16'(n), 16'(9 * UNIT));
		chk("middle", 16'({mid_l, mid_r, out_l, out_r}), 16'hc);
		u_host.step(8'h54, 4'h0, 3'h5, 8'h33, 4'h9, 1'b1, n);
		chk("step_len", 16'(n), 16'(520 * UNIT));
		u_host.step(8'h60, 4'h0, 3'h7, 8'hee, 4'h0, 1'b1, n);
		chk("step_len", 16'(n), 16'(9 * UNIT));
		chk("shorted", 16'({sh_l, sh_r, out_l, out_r}), 16'h3);
		rdchk("hp0", 8'h60, 16'h00ee);
		rdchk("pwr1", 8'h01, 16'h030b);
		u_host.step(8'h60, 4'h0, 3'h7, 8'h00, 4'h0, 1'b0, n);
		u_host.step(8'h60, 4'h0, 3'h7, 8'hff, 4'h0, 1'b0, n);
		chk("busy", 16'(seq_busy), 16'h0001);
		repeat (9 * UNIT) @(negedge system_clock);
		chk("busy", 16'(seq_busy), 16'h0000);
		rdchk("hp0", 8'h60, 16'h0000);
		$display("test sequencer done");
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
